// *** logic/perf_mon_pkg.sv ***
package perf_mon_pkg;
    // ************************************************************
    // Register map
    // ************************************************************
    localparam int          ADDR_W     = 8;
    localparam int          DATA_W     = 8;
    localparam logic [7:0]  OFF_CTRL   = 8'h44;
    localparam logic [7:0]  OFF_DATA0  = 8'h48;
    localparam logic [7:0]  OFF_DATA1  = 8'h49;
    localparam logic [7:0]  OFF_SDCFG  = 8'h4c;
    localparam int          SEL0_LSB   = 0;
    localparam int          SEL1_LSB   = 4;
    localparam int          SEL_W      = 3;
    localparam int          PG_LSB     = 0;
    localparam int          BANK4_BIT  = 2;
    localparam int          WBEN_BIT   = 3;
    localparam int          WM_LSB     = 4;
    localparam logic [7:0]  CTRL_RST   = 8'h00;
    localparam logic [7:0]  SDCFG_RST  = 8'h00;
    // ************************************************************
    // Integrator and tracker constants
    // ************************************************************
    localparam logic [7:0]  EST_INIT   = 8'h80;
    localparam logic [7:0]  EST_FULL   = 8'hff;
    localparam logic [7:0]  EST_ZERO   = 8'h00;
    localparam int          LFSR_W     = 31;
    localparam int          TAP_A      = 30;
    localparam int          TAP_B      = 27;
    localparam logic [30:0] SEED0      = 31'h2a5c_3e17;
    localparam logic [30:0] SEED1      = 31'h1357_9bdf;
    localparam int          ADR_W      = 27;
    localparam int          PAGE_BASE  = 10;
    localparam int          ROW_W      = 14;
    localparam int          LVL_W      = 6;

    typedef enum logic [2:0] {
        PM_OFF       = 3'b000,
        PM_WB_HIT    = 3'b001,
        PM_RD_MERGE  = 3'b010,
        PM_WB_FULL   = 3'b011,
        PM_RB_HIT    = 3'b100,
        PM_PAGE_MISS = 3'b101
    } param_e;

    typedef struct packed {
        logic smp;
        logic hit;
    } event_s;

    typedef struct packed {
        event_s wb_hit;
        event_s rd_merge;
        event_s wb_full;
        event_s rb_hit;
    } events_s;

    typedef struct packed {
        logic             valid;
        logic [ADR_W-1:0] addr;
    } access_s;
endpackage

// *** logic/perf_monitor_pair.sv ***
// Strobed register access and the register offsets were chosen for this implementation.
`timescale 1ns/1ns
module perf_monitor_pair #(
    parameter int CNT_W = 8
) (
    input  wire logic                                clk,
    input  wire logic                                reset_n,
    input  wire logic                                prog_reset,
    input  wire logic [perf_mon_pkg::ADDR_W-1:0]     addr,
    input  wire logic [perf_mon_pkg::DATA_W-1:0]     wdata,
    input  wire logic                                wr_stb,
    input  wire logic                                rd_stb,
    output logic      [perf_mon_pkg::DATA_W-1:0]     rdata,
    input  wire perf_mon_pkg::events_s               events,
    input  wire perf_mon_pkg::access_s               access,
    input  wire logic                                refresh,
    input  wire logic                                rd_pending,
    input  wire logic [perf_mon_pkg::LVL_W-1:0]      wb_level,
    output logic                                     grant_rd,
    output logic                                     grant_wb,
    output logic                                     wb_req,
    output logic                                     page_miss
);
    // ************************************************************
    // Elaboration checks
    // ************************************************************
    if (CNT_W != 8) begin : g_bad_width
        $error("Counter width must be 8 to match the register width");
    end

    // ************************************************************
    // Reset synchroniser
    // ************************************************************
    logic                           rst_meta_ff;
    logic                           rst_n_ff;
    logic [7:0]                     ctrl_ff;
    logic [7:0]                     sdcfg_ff;
    logic [7:0]                     rdata_ff;
    logic [CNT_W-1:0]               est_ff [2];
    logic [perf_mon_pkg::LFSR_W-1:0] lfsr_ff [2];
    logic [3:0]                     open_ff;
    logic [perf_mon_pkg::ROW_W-1:0] row_ff [4];
    logic                           pm_smp_ff;
    logic                           pm_miss_ff;
    logic                           grant_rd_ff;
    logic                           grant_wb_ff;
    logic                           wb_req_ff;
    logic [1:0]                     bank;
    logic [perf_mon_pkg::ROW_W-1:0] row;
    logic [perf_mon_pkg::ADR_W-1:0] shifted;
    logic                           four;
    logic                           miss;

    // Release reset through two flops
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rst_meta_ff <= 1'b0;
            rst_n_ff    <= 1'b0;
        end else begin
            rst_meta_ff <= 1'b1;
            rst_n_ff    <= rst_meta_ff;
        end
    end

    // ************************************************************
    // Register file
    // ************************************************************
    // Control regs clear only on power-on reset
    always_ff @(posedge clk or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            ctrl_ff  <= perf_mon_pkg::CTRL_RST;
            sdcfg_ff <= perf_mon_pkg::SDCFG_RST;
        end else if (wr_stb) begin
            if (addr == perf_mon_pkg::OFF_CTRL) begin
                ctrl_ff <= wdata;
            end
            if (addr == perf_mon_pkg::OFF_SDCFG) begin
                sdcfg_ff <= wdata;
            end
        end
    end

    // Read data valid only in the cycle after the strobe
    always_ff @(posedge clk or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            rdata_ff <= 8'h00;
        end else if (rd_stb) begin
            unique case (addr)
                perf_mon_pkg::OFF_CTRL:  rdata_ff <= ctrl_ff;
                perf_mon_pkg::OFF_DATA0: rdata_ff <= est_ff[0];
                perf_mon_pkg::OFF_DATA1: rdata_ff <= est_ff[1];
                perf_mon_pkg::OFF_SDCFG: rdata_ff <= sdcfg_ff;
                default:                 rdata_ff <= 8'h00;
            endcase
        end else begin
            rdata_ff <= 8'h00;
        end
    end

    // ************************************************************
    // Page and bank tracking
    // ************************************************************
    // Split address by programmed page width and bank count
    always_comb begin
        four    = sdcfg_ff[perf_mon_pkg::BANK4_BIT];
        shifted = access.addr >> (perf_mon_pkg::PAGE_BASE
                  + int'(sdcfg_ff[perf_mon_pkg::PG_LSB +: 2]));
        bank    = four ? shifted[1:0] : {1'b0, shifted[0]};
        row     = four ? shifted[perf_mon_pkg::ROW_W+1:2]
                       : shifted[perf_mon_pkg::ROW_W:1];
        miss    = !open_ff[bank] || (row_ff[bank] != row);
    end

    // One open page per bank; refresh closes all banks not accessed in the same cycle
    for (genvar b = 0; b < 4; b++) begin : g_bank
        always_ff @(posedge clk or negedge rst_n_ff) begin
            if (!rst_n_ff) begin
                open_ff[b] <= 1'b0;
                row_ff[b]  <= '0;
            end else if (access.valid && bank == 2'(b)) begin
                open_ff[b] <= 1'b1;
                row_ff[b]  <= row;
            end else if (refresh) begin
                open_ff[b] <= 1'b0;
            end
        end
    end

    // Miss event, one per request
    always_ff @(posedge clk or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            pm_smp_ff  <= 1'b0;
            pm_miss_ff <= 1'b0;
        end else begin
            pm_smp_ff <= access.valid;
            if (access.valid) begin
                pm_miss_ff <= miss;
            end
        end
    end

    // ************************************************************
    // Write buffer request and arbitration
    // ************************************************************
    // Watermark request and read-first grant
    always_ff @(posedge clk or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            wb_req_ff   <= 1'b0;
            grant_rd_ff <= 1'b0;
            grant_wb_ff <= 1'b0;
        end else begin
            wb_req_ff   <= sdcfg_ff[perf_mon_pkg::WBEN_BIT] && (wb_level >=
                           {1'b0, sdcfg_ff[perf_mon_pkg::WM_LSB +: 4], 1'b0});
            grant_rd_ff <= rd_pending;
            grant_wb_ff <= wb_req_ff && !rd_pending;
        end
    end

    // ************************************************************
    // Integrators
    // ************************************************************
    for (genvar m = 0; m < 2; m++) begin : g_mon
        perf_mon_pkg::param_e sel;
        logic                 smp;
        logic                 bit_v;
        logic                 cmp;

        // Steer selected event stream
        always_comb begin
            sel   = perf_mon_pkg::param_e'(ctrl_ff[m*4 +: perf_mon_pkg::SEL_W]);
            smp   = 1'b0;
            bit_v = 1'b0;
            unique case (sel)
                perf_mon_pkg::PM_OFF: begin
                    smp = 1'b0;
                end
                perf_mon_pkg::PM_WB_HIT: begin
                    smp   = events.wb_hit.smp;
                    bit_v = events.wb_hit.hit;
                end
                perf_mon_pkg::PM_RD_MERGE: begin
                    smp   = events.rd_merge.smp;
                    bit_v = events.rd_merge.hit;
                end
                perf_mon_pkg::PM_WB_FULL: begin
                    smp   = events.wb_full.smp;
                    bit_v = events.wb_full.hit;
                end
                perf_mon_pkg::PM_RB_HIT: begin
                    smp   = events.rb_hit.smp;
                    bit_v = events.rb_hit.hit;
                end
                perf_mon_pkg::PM_PAGE_MISS: begin
                    smp   = pm_smp_ff;
                    bit_v = pm_miss_ff;
                end
                default: begin
                    smp = 1'b0;
                end
            endcase
            cmp = est_ff[m] > lfsr_ff[m][perf_mon_pkg::LFSR_W-1 -: CNT_W];
        end

        // Random source steps once per sample
        always_ff @(posedge clk or negedge rst_n_ff) begin
            if (!rst_n_ff) begin
                lfsr_ff[m] <= (m == 0) ? perf_mon_pkg::SEED0 : perf_mon_pkg::SEED1;
            end else if (smp) begin
                lfsr_ff[m] <= {lfsr_ff[m][perf_mon_pkg::LFSR_W-2:0],
                               lfsr_ff[m][perf_mon_pkg::TAP_A]
                               ^ lfsr_ff[m][perf_mon_pkg::TAP_B]};
            end
        end

        // Estimate moves toward the event bit, saturating
        always_ff @(posedge clk or negedge rst_n_ff) begin
            if (!rst_n_ff) begin
                est_ff[m] <= perf_mon_pkg::EST_INIT;
            end else if (prog_reset) begin
                est_ff[m] <= perf_mon_pkg::EST_INIT;
            end else if (smp && (cmp != bit_v)) begin
                if (bit_v && est_ff[m] != perf_mon_pkg::EST_FULL) begin
                    est_ff[m] <= est_ff[m] + 8'h01;
                end else if (!bit_v && est_ff[m] != perf_mon_pkg::EST_ZERO) begin
                    est_ff[m] <= est_ff[m] - 8'h01;
                end
            end
        end
    end

    assign rdata     = rdata_ff;
    assign grant_rd  = grant_rd_ff;
    assign grant_wb  = grant_wb_ff;
    assign wb_req    = wb_req_ff;
    assign page_miss = pm_miss_ff;

    // ************************************************************
    // Assertions
    // ************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n_ff);

    // Monitor 0 sample and event bit taps for the checks
    logic en0;
    logic hit0;
    assign en0 = g_mon[0].smp;
    assign hit0 = g_mon[0].bit_v;

    init_mid_a: assert property (prog_reset |=> est_ff[0] == 8'h80 && est_ff[1] == 8'h80)
        else $error("Estimate not midscale after programmable reset");
    ctrl_keep_a: assert property (prog_reset && !wr_stb |=> $stable(ctrl_ff))
        else $error("Selection changed across programmable reset");
    no_clear_a: assert property (wr_stb && addr == perf_mon_pkg::OFF_DATA0 && !en0 && !prog_reset
                                 |=> $stable(est_ff[0]))
        else $error("Write disturbed estimate");
    hold_off_a: assert property (ctrl_ff[2:0] == 3'b000 && !prog_reset
                                 |=> $stable(est_ff[0]))
        else $error("Disabled monitor changed");
    step_one_a: assert property (!prog_reset |=> (est_ff[0] - $past(est_ff[0]) <= 8'h01)
                                 || ($past(est_ff[0]) - est_ff[0] <= 8'h01))
        else $error("Estimate stepped by more than one");
    no_wrap_a: assert property (est_ff[0] == 8'hff && !prog_reset |=> est_ff[0] >= 8'hfe)
        else $error("Estimate wrapped");
    refresh_miss_a: assert property (refresh && !access.valid ##1 access.valid
                                     |=> pm_miss_ff)
        else $error("First access after refresh not a miss");
    read_prio_a: assert property (rd_pending |=> grant_rd_ff && !grant_wb_ff)
        else $error("Write-back granted over pending read");
    wm_req_a: assert property (sdcfg_ff[3] && wb_level >= {1'b0, sdcfg_ff[7:4], 1'b0}
                               && !wr_stb |=> wb_req_ff)
        else $error("Watermark reached without write-back request");
    read_back_a: assert property (rd_stb && addr == perf_mon_pkg::OFF_DATA0
                                  |=> rdata_ff == $past(est_ff[0]))
        else $error("Readout differs from estimate");
    lfsr_step_a: assert property (en0 |=> lfsr_ff[0] != $past(lfsr_ff[0]))
        else $error("Random source did not advance");

    // Monitor 1, monitor 0 step, read port, arbiter, tracker and setup checks
    read_one_a: assert property (rd_stb && addr == perf_mon_pkg::OFF_DATA1
                                 |=> rdata_ff == $past(est_ff[1]))
        else $error("Readout differs from estimate of monitor 1");
    rd_idle_a: assert property (!rd_stb |=> rdata_ff == 8'h00)
        else $error("Read data present without a read");
    hold_mon1_a: assert property (ctrl_ff[6:4] == 3'h0 && !prog_reset
                                  |=> $stable(est_ff[1]))
        else $error("Disabled monitor 1 changed");
    step_up_a: assert property (en0 && hit0 && !prog_reset
                                |=> est_ff[0] >= $past(est_ff[0]))
        else $error("Estimate moved away from a set event bit");
    floor_hold_a: assert property (est_ff[1] == 8'h00 && !prog_reset
                                   |=> est_ff[1] <= 8'h01)
        else $error("Estimate wrapped below zero");
    grant_wb_a: assert property (wb_req_ff && !rd_pending |=> grant_wb_ff)
        else $error("Write-back not granted while no read pends");
    wb_off_a: assert property (!sdcfg_ff[perf_mon_pkg::WBEN_BIT] |=> !wb_req_ff)
        else $error("Write-back requested with write buffer disabled");
    miss_closed_a: assert property (access.valid && !open_ff[bank] |=> pm_miss_ff)
        else $error("Access to a closed bank not reported as miss");
    cfg_keep_a: assert property (prog_reset && !wr_stb |=> $stable(sdcfg_ff))
        else $error("Controller setup changed across programmable reset");

    // Main scenarios
    full_scale_c: cover property (est_ff[0] == 8'hff);
    refresh_seq_c: cover property (refresh ##1 access.valid ##1 pm_miss_ff);
    reselect_c: cover property (en0 ##1 wr_stb && addr == perf_mon_pkg::OFF_CTRL ##1 en0);
    zero_scale_c: cover property (est_ff[1] == 8'h00);
    prio_clash_c: cover property (rd_pending && wb_req_ff);
endmodule

// *** tb/event_source.sv ***
`timescale 1ns/1ns
module event_source (
    input  wire logic                  clk,
    input  wire logic                  run,
    input  wire logic [8:0]            rate,
    input  wire logic [26:0]           base,
    output perf_mon_pkg::events_s      events,
    output perf_mon_pkg::access_s      access
);
    // ********************
    // Stream generation
    // ********************
    int         seed = 88792;
    logic       ph_ff = 1'b0;
    logic [7:0] ev;

    // Idle lines start low
    initial begin
        events = '0;
        access = '0;
    end

    // One sample per tenure every other cycle; idle hit bits and address toggle
    always @(posedge clk) begin
        ph_ff <= run ? !ph_ff : 1'b0;
        for (int i = 0; i < 4; i++) begin
            ev[2*i+1] = run && !ph_ff;
            ev[2*i] = ev[2*i+1] ? (($random(seed) & 32'hff) < 32'(rate)) : !events[2*i];
        end
        events <= ev;
        access.valid <= run && !ph_ff;
        access.addr <= (run && !ph_ff) ? base : ~access.addr;
    end
endmodule

// *** tb/testbench.sv ***
`timescale 1ns/1ns
module testbench;
    logic                  clk = 1'b0;
    logic                  reset_n = 1'b0;
    logic                  prog_reset = 1'b0;
    logic [7:0]            addr = 8'h00;
    logic [7:0]            wdata = 8'h00;
    logic                  wr_stb = 1'b0;
    logic                  rd_stb = 1'b0;
    logic                  refresh = 1'b0;
    logic                  rd_pending = 1'b0;
    logic [5:0]            wb_level = 6'h00;
    logic                  run = 1'b0;
    logic [8:0]            rate = 9'h000;
    perf_mon_pkg::access_s t_acc = '0;
    perf_mon_pkg::access_s p_acc;
    perf_mon_pkg::access_s acc;
    perf_mon_pkg::events_s events;
    logic [7:0]            rdata;
    logic                  grant_rd;
    logic                  grant_wb;
    logic                  wb_req;
    logic                  page_miss;
    logic [7:0]            d0;
    logic [7:0]            d1;
    logic [7:0]            p0;
    logic [7:0]            p1;
    int                    seed = 88792;
    int                    miscompares = 0;
    int                    checks = 0;
    int                    wm;
    int                    wb;
    int                    lvl;
    int                    rp;

    // Bench drives accesses only while the source model is idle
    assign acc = run ? p_acc : t_acc;

    // Free running clock, 8 ns
    initial begin
        forever #4 clk = !clk;
    end

    perf_monitor_pair #(.CNT_W(8)) dut (.clk(clk), .reset_n(reset_n), .prog_reset(prog_reset),
        .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata),
        .events(events), .access(acc), .refresh(refresh), .rd_pending(rd_pending),
        .wb_level(wb_level), .grant_rd(grant_rd), .grant_wb(grant_wb), .wb_req(wb_req),
        .page_miss(page_miss));

    event_source src (.clk(clk), .run(run), .rate(rate), .base(27'h0000400),
        .events(events), .access(p_acc));

    // ********************
    // Helpers
    // ********************
    task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task summarize;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr_stb <= 1'b1;
        @(posedge clk);
        wr_stb <= 1'b0;
    endtask

    task rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        addr <= a;
        rd_stb <= 1'b1;
        @(posedge clk);
        rd_stb <= 1'b0;
        #1 d = rdata;
    endtask

    task acc_chk(input logic [26:0] a, input logic exp);
        @(posedge clk);
        refresh <= 1'b0;
        t_acc <= '{valid: 1'b1, addr: a};
        @(posedge clk);
        t_acc <= '{valid: 1'b0, addr: ~a};
        #1 check("page_miss", 32'(page_miss), 32'(exp));
    endtask

    function logic exp_req(int en, int level, int mark);
        return en != 0 && level >= 2 * mark;
    endfunction

    // Watchdog against a hang
    initial begin
        #600000;
        miscompares++;
        summarize();
    end

    // ********************
    // Main sequence
    // ********************
    initial begin
        repeat (10) @(posedge clk);
        reset_n <= 1'b1;
        repeat (3) @(posedge clk);
        rd(perf_mon_pkg::OFF_CTRL, d0);
        check("ctrl", d0, perf_mon_pkg::CTRL_RST);
        rd(perf_mon_pkg::OFF_DATA0, d0);
        check("data0", d0, perf_mon_pkg::EST_INIT);
        wr(perf_mon_pkg::OFF_DATA0, 8'h00);
        wr(8'h10, 8'hff);
        rd(8'h10, d1);
        check("unmapped", d1, 8'h00);
        run <= 1'b1;
        rate <= 9'h100;
        repeat (200) @(posedge clk);
        rd(perf_mon_pkg::OFF_DATA0, d0);
        rd(perf_mon_pkg::OFF_DATA1, d1);
        check("idle", {d0, d1}, {2{perf_mon_pkg::EST_INIT}});
        $display("test reset done");
        wr(perf_mon_pkg::OFF_CTRL, {1'b0, perf_mon_pkg::PM_PAGE_MISS, 1'b0, perf_mon_pkg::PM_RB_HIT});
        rd(perf_mon_pkg::OFF_CTRL, d0);
        check("ctrl", d0, 8'h54);
        p0 = perf_mon_pkg::EST_INIT;
        p1 = perf_mon_pkg::EST_INIT;
        for (int n = 0; n < 400 && !(p0 === 8'hff && p1 === 8'h00); n++) begin
            repeat (30) @(posedge clk);
            rd(perf_mon_pkg::OFF_DATA0, d0);
            rd(perf_mon_pkg::OFF_DATA1, d1);
            check("rising", 32'(d0 >= p0), 1);
            check("falling", 32'(d1 <= p1), 1);
            p0 = d0;
            p1 = d1;
        end
        check("converge", {p0, p1}, {perf_mon_pkg::EST_FULL, perf_mon_pkg::EST_ZERO});
        repeat (400) @(posedge clk);
        rd(perf_mon_pkg::OFF_DATA0, d0);
        rd(perf_mon_pkg::OFF_DATA1, d1);
        check("saturate", {d0, d1}, {perf_mon_pkg::EST_FULL, perf_mon_pkg::EST_ZERO});
        rate <= 9'h000;
        wr(perf_mon_pkg::OFF_CTRL, {1'b0, perf_mon_pkg::PM_PAGE_MISS, 1'b0, perf_mon_pkg::PM_WB_FULL});
        repeat (40) @(posedge clk);
        rd(perf_mon_pkg::OFF_DATA0, d0);
        check("adapt", 32'(d0 >= 8'hc0 && d0 < 8'hff), 1);
        wr(perf_mon_pkg::OFF_CTRL, {1'b0, perf_mon_pkg::PM_PAGE_MISS, 4'h0});
        rd(perf_mon_pkg::OFF_DATA0, d0);
        repeat (300) @(posedge clk);
        rd(perf_mon_pkg::OFF_DATA0, d1);
        check("frozen", d1, d0);
        rate <= 9'h100;
        wr(perf_mon_pkg::OFF_CTRL, {1'b0, perf_mon_pkg::PM_RD_MERGE, 1'b0, perf_mon_pkg::PM_WB_HIT});
        repeat (200) @(posedge clk);
        rd(perf_mon_pkg::OFF_DATA0, d0);
        rd(perf_mon_pkg::OFF_DATA1, p1);
        check("wb_hit", 32'(d0 > d1), 1);
        check("rd_merge", 32'(p1 > 8'h00 && p1 < 8'hff), 1);
        run <= 1'b0;
        repeat (4) @(posedge clk);
        prog_reset <= 1'b1;
        @(posedge clk);
        prog_reset <= 1'b0;
        rd(perf_mon_pkg::OFF_DATA0, d0);
        rd(perf_mon_pkg::OFF_DATA1, d1);
        check("cleared", {d0, d1}, {2{perf_mon_pkg::EST_INIT}});
        rd(perf_mon_pkg::OFF_CTRL, d0);
        check("ctrl kept", d0, 8'h21);
        $display("test integrate done");
        for (int p = 0; p < 4; p++) begin
            for (int b = 0; b < 2; b++) begin
                wr(perf_mon_pkg::OFF_SDCFG, 8'((b << 2) | p));
                rd(perf_mon_pkg::OFF_SDCFG, d0);
                check("sdcfg", d0, 8'((b << 2) | p));
                @(posedge clk);
                refresh <= 1'b1;
                acc_chk(27'h0, 1'b1);
                acc_chk(27'(1 << (9 + p)), 1'b0);
                acc_chk(27'(1 << (10 + p)), 1'b1);
                acc_chk(27'h0, 1'b0);
                acc_chk(27'(1 << (11 + p + b)), 1'b1);
            end
        end
        $display("test pages done");
        for (int n = 0; n < 40; n++) begin
            wm = $unsigned($random(seed)) % 16;
            wb = $unsigned($random(seed)) % 2;
            lvl = $unsigned($random(seed)) % 33;
            rp = $unsigned($random(seed)) % 2;
            if (n < 2) begin
                wm = 5;
                wb = 1;
                lvl = 10 - n;
                rp = 0;
            end
            wr(perf_mon_pkg::OFF_SDCFG, 8'((wm << 4) | (wb << 3)));
            wb_level <= 6'(lvl);
            rd_pending <= 1'(rp);
            repeat (3) @(posedge clk);
            #1 check("wb_req", 32'(wb_req), 32'(exp_req(wb, lvl, wm)));
            check("grant_wb", 32'(grant_wb), 32'(exp_req(wb, lvl, wm) && rp == 0));
            check("grant_rd", 32'(grant_rd), 32'(rp));
        end
        $display("test arbiter done");
        summarize();
    end
endmodule
